//--- rtl/faec_module_seq.v
// one flash module's erase/program sequencer
`timescale 1ns/10ps
module faec_module_seq #(
  parameter CNT_W = 20
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  input wire fclk_en,
  // command
  input wire start,
  input wire [1:0] cmd,
  input wire [CNT_W-1:0] erase_ticks,
  input wire [CNT_W-1:0] prog_ticks,
  // state
  output reg busy_reg,
  output reg done_reg
);
  `include "faec_regs.vh"
  localparam [CNT_W-1:0] OVERHEAD = `FAEC_SM_OVERHEAD;
  localparam S_IDLE = 2'h0;
  localparam S_PRE = 2'h1;
  localparam S_RUN = 2'h2;
  localparam S_POST = 2'h3;
  reg [1:0] state_reg;
  reg [CNT_W-1:0] cnt_reg;
  // the command only stands for one cycle, so its kind is kept here
  reg erase_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
      erase_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            busy_reg <= 1'b1;
            state_reg <= S_PRE;
            cnt_reg <= OVERHEAD;
            erase_reg <= (cmd == `FAEC_CMD_ERASE);
          end
        end
        S_PRE: begin
          if (cnt_reg == {CNT_W{1'b0}}) begin
            state_reg <= S_RUN;
            cnt_reg <= erase_reg ? erase_ticks : prog_ticks;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_RUN: begin
          // timed on the slow flash clock enable, not the system clock
          if (fclk_en) begin
            if (cnt_reg <= 1) begin
              state_reg <= S_POST;
              cnt_reg <= OVERHEAD;
            end else begin
              cnt_reg <= cnt_reg - 1'b1;
            end
          end
        end
        S_POST: begin
          if (cnt_reg == {CNT_W{1'b0}}) begin
            state_reg <= S_IDLE;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

//--- rtl/faec_regs.vh
// timing, command and reset constants for the flash access and erase controller
`ifndef FAEC_REGS_VH
`define FAEC_REGS_VH
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define FAEC_CLK_MHZ 100
`define FAEC_ERASE_TIME_US 8000
`define FAEC_PROG_TIME_US 3500
`define FAEC_ERASE_CYCLES (`FAEC_ERASE_TIME_US * `FAEC_CLK_MHZ)
`define FAEC_PROG_CYCLES (`FAEC_PROG_TIME_US * `FAEC_CLK_MHZ)
`define FAEC_FCLK_DIV 20
`define FAEC_SM_OVERHEAD 4
// -----------------------------------------------------------------
// commands and reset values
// -----------------------------------------------------------------
`define FAEC_CMD_ERASE 2'h1
`define FAEC_CMD_PROG 2'h2
`define FAEC_WAIT_RESET 3'h4
`define FAEC_ERASED_WORD 16'hFFFF
`endif

//--- rtl/faec_top.v
// flash access, wait-state/prefetch and erase/program control
`timescale 1ns/10ps
// Function
// - after reset no protection is active and reads of unwritten sectors give erased data.
// - sector or page erase finishes within 8.0 ms.
// - page program finishes within 3.5 ms.
// - module 1 accepts modify while module 0 is being read.
// - wait states apply only to non-sequential reads; sequential ones use prefetch.
// - durations run on a flash clock plus a few system clock cycles overhead.
`include "faec_regs.vh"
module faec_top #(
  parameter MODULES = 2,
  parameter ADDR_W = 16,
  parameter DATA_W = 16,
  parameter CNT_W = 20,
  parameter ERASE_TICKS = `FAEC_ERASE_CYCLES / `FAEC_FCLK_DIV,
  parameter PROG_TICKS = `FAEC_PROG_CYCLES / `FAEC_FCLK_DIV
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // configuration
  input wire [2:0] flash_wait_state_count,
  // read port from the internal memory bus
  input wire rd_req,
  input wire [ADDR_W-1:0] rd_addr,
  input wire [0:0] rd_module,
  input wire [DATA_W-1:0] array_rdata,
  output reg rd_valid_reg,
  output reg [DATA_W-1:0] rd_data_reg,
  output reg rd_busy_reg,
  // command port
  input wire cmd_valid,
  input wire [1:0] cmd,
  input wire [0:0] cmd_module,
  output reg cmd_refused_reg,
  // status
  output reg [MODULES-1:0] module_busy_reg,
  output reg [MODULES-1:0] module_done_reg,
  output reg protect_active_reg
);
  // -----------------------------------------------------------------
  // flash clock enable divider
  // -----------------------------------------------------------------
  localparam [7:0] DIV_LAST = `FAEC_FCLK_DIV - 1;
  reg [7:0] div_reg;
  reg [7:0] div_next;
  reg fclk_en_reg;
  reg fclk_en_next;
  // the flash timebase is an enable pulse, so every flop stays on the one clock
  always @* begin
    div_next = div_reg + 8'h01;
    fclk_en_next = 1'b0;
    if (div_reg == DIV_LAST) begin
      div_next = 8'h00;
      fclk_en_next = 1'b1;
    end
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 8'h00;
      fclk_en_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      fclk_en_reg <= fclk_en_next;
    end
  end
  // -----------------------------------------------------------------
  // per-module sequencers
  // -----------------------------------------------------------------
  wire [MODULES-1:0] seq_busy;
  wire [MODULES-1:0] seq_done;
  wire [MODULES-1:0] seq_start;
  wire [CNT_W-1:0] erase_cnt;
  wire [CNT_W-1:0] prog_cnt;
  wire cmd_known;
  wire cmd_ok;
  wire target_busy;
  reg [MODULES-1:0] module_busy_next;
  reg cmd_refused_next;
  // tick counts are cut to the counter width on purpose
  assign erase_cnt = ERASE_TICKS[CNT_W-1:0];
  assign prog_cnt = PROG_TICKS[CNT_W-1:0];
  assign cmd_known = (cmd == `FAEC_CMD_ERASE) || (cmd == `FAEC_CMD_PROG);
  assign cmd_ok = cmd_valid && cmd_known;
  // read conflicts are software's duty; hardware only guards a busy target
  // the reported flag is used, so a command is never taken while it still shows busy
  assign target_busy = module_busy_reg[cmd_module];
  genvar gi;
  generate
    for (gi = 0; gi < MODULES; gi = gi + 1) begin : g_mod
      assign seq_start[gi] = cmd_ok && !target_busy && (cmd_module == gi);
      faec_module_seq #(.CNT_W(CNT_W)) u_seq (
        .clk(clk),
        .rst_b(rst_b),
        .fclk_en(fclk_en_reg),
        .start(seq_start[gi]),
        .cmd(cmd),
        .erase_ticks(erase_cnt),
        .prog_ticks(prog_cnt),
        .busy_reg(seq_busy[gi]),
        .done_reg(seq_done[gi])
      );
    end
  endgenerate
  always @* begin
    module_busy_next = seq_busy | seq_start;
    cmd_refused_next = cmd_valid && (!cmd_known || target_busy);
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      module_busy_reg <= {MODULES{1'b0}};
      module_done_reg <= {MODULES{1'b0}};
      cmd_refused_reg <= 1'b0;
      protect_active_reg <= 1'b0;
    end else begin
      module_busy_reg <= module_busy_next;
      module_done_reg <= seq_done;
      cmd_refused_reg <= cmd_refused_next;
      protect_active_reg <= 1'b0;
    end
  end
  // -----------------------------------------------------------------
  // read path with sequential prefetch
  // -----------------------------------------------------------------
  localparam R_IDLE = 1'b0;
  localparam R_WAIT = 1'b1;
  reg rd_state_reg;
  reg rd_state_next;
  reg [ADDR_W-1:0] last_addr_reg;
  reg [ADDR_W-1:0] last_addr_next;
  reg last_mod_reg;
  reg last_mod_next;
  reg last_ok_reg;
  reg last_ok_next;
  reg [2:0] ws_cnt_reg;
  reg [2:0] ws_cnt_next;
  reg [DATA_W-1:0] pend_data_reg;
  reg [DATA_W-1:0] pend_data_next;
  reg rd_valid_next;
  reg [DATA_W-1:0] rd_data_next;
  reg rd_busy_next;
  wire [ADDR_W-1:0] next_seq_addr;
  wire seq_hit;
  wire no_wait;
  assign next_seq_addr = last_addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
  // the prefetch buffer only ever holds the word after the last one read
  assign seq_hit = last_ok_reg && (rd_module == last_mod_reg) && (rd_addr == next_seq_addr);
  assign no_wait = seq_hit || (flash_wait_state_count == 3'h0);
  always @* begin
    rd_state_next = rd_state_reg;
    last_addr_next = last_addr_reg;
    last_mod_next = last_mod_reg;
    last_ok_next = last_ok_reg;
    ws_cnt_next = ws_cnt_reg;
    pend_data_next = pend_data_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    rd_busy_next = rd_busy_reg;
    case (rd_state_reg)
      R_IDLE: begin
        if (rd_req) begin
          last_addr_next = rd_addr;
          last_mod_next = rd_module;
          last_ok_next = 1'b1;
          if (no_wait) begin
            // sequential hit or zero wait states configured: word is ready, no wait states
            rd_valid_next = 1'b1;
            rd_data_next = array_rdata;
          end else begin
            // non-sequential: hold the word for the configured wait states
            rd_state_next = R_WAIT;
            rd_busy_next = 1'b1;
            ws_cnt_next = flash_wait_state_count;
            pend_data_next = array_rdata;
          end
        end
      end
      R_WAIT: begin
        // requests are ignored here; the word was captured when it was asked for
        if (ws_cnt_reg <= 3'h1) begin
          rd_state_next = R_IDLE;
          rd_busy_next = 1'b0;
          rd_valid_next = 1'b1;
          rd_data_next = pend_data_reg;
        end else begin
          ws_cnt_next = ws_cnt_reg - 3'h1;
        end
      end
      default: begin
        rd_state_next = R_IDLE;
        rd_busy_next = 1'b0;
      end
    endcase
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_state_reg <= R_IDLE;
      last_addr_reg <= {ADDR_W{1'b0}};
      last_mod_reg <= 1'b0;
      last_ok_reg <= 1'b0;
      ws_cnt_reg <= 3'h0;
      pend_data_reg <= {DATA_W{1'b0}};
      rd_valid_reg <= 1'b0;
      rd_data_reg <= `FAEC_ERASED_WORD;
      rd_busy_reg <= 1'b0;
    end else begin
      rd_state_reg <= rd_state_next;
      last_addr_reg <= last_addr_next;
      last_mod_reg <= last_mod_next;
      last_ok_reg <= last_ok_next;
      ws_cnt_reg <= ws_cnt_next;
      pend_data_reg <= pend_data_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
      rd_busy_reg <= rd_busy_next;
    end
  end
endmodule

//--- verification/faec_mem_model.sv
// flash array model answering the controller's read port
`timescale 1ns/10ps
module faec_mem_model (
  // bus side
  input wire clk, input wire rd_req, input wire [15:0] rd_addr, input wire [0:0] rd_module,
  // array word
  output reg [15:0] array_rdata
);
  reg [15:0] last_reg = 16'h0;
  // idle word toggles each cycle so a stale capture cannot match
  always @* array_rdata = rd_req ? ({rd_module, rd_addr[14:0]} ^ 16'h3C3C) : ~last_reg;
  always @(posedge clk) last_reg <= array_rdata;
endmodule

//--- verification/faec_top_properties.sv
// port-level assertions for the flash access and erase controller
`timescale 1ns/10ps
module faec_chk #(parameter ERASE_TICKS = 5, parameter PROG_TICKS = 3) (
  input wire clk, input wire rst_b, input wire [2:0] flash_wait_state_count,
  input wire rd_req, input wire [15:0] rd_addr, input wire [0:0] rd_module,
  input wire [15:0] array_rdata, input wire rd_valid_reg, input wire [15:0] rd_data_reg,
  input wire rd_busy_reg, input wire cmd_valid, input wire [1:0] cmd,
  input wire [0:0] cmd_module, input wire cmd_refused_reg, input wire [1:0] module_busy_reg,
  input wire [1:0] module_done_reg, input wire protect_active_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg have_reg, k_reg;
  reg [15:0] last_reg, dat_reg;
  reg [0:0] mod_reg;
  reg [2:0] ws_reg, bc_reg;
  reg [31:0] c_reg;
  wire take = rd_req && !rd_busy_reg;
  wire seq = have_reg && rd_addr == last_reg + 16'h1 && rd_module == mod_reg;
  // duration window allows one flash clock tick of jitter either way
  wire [31:0] t = (k_reg ? PROG_TICKS : ERASE_TICKS) * 20;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      have_reg <= 1'b0;
      bc_reg <= 3'h0;
      c_reg <= 32'h0;
    end else begin
      bc_reg <= rd_busy_reg ? bc_reg + 3'h1 : 3'h0;
      c_reg <= module_busy_reg[0] ? c_reg + 32'h1 : 32'h0;
      if (take) begin
        have_reg <= 1'b1;
        last_reg <= rd_addr;
        mod_reg <= rd_module;
        dat_reg <= array_rdata;
        ws_reg <= flash_wait_state_count;
      end
    end
  end
  always @(posedge clk) if (cmd_valid && cmd_module == 1'h0 && !module_busy_reg[0]) begin
    k_reg <= cmd == 2'h2;
  end
  property p_prot; protect_active_reg == 1'b0; endproperty
  a_prot: assert property (p_prot) else $error("protection active");
  property p_seq; take && (seq || flash_wait_state_count == 3'h0) |=> rd_valid_reg && !rd_busy_reg;
  endproperty
  a_seq: assert property (p_seq) else $error("fast read late");
  property p_cnt; rd_valid_reg && $past(rd_busy_reg) |-> bc_reg == ws_reg; endproperty
  a_cnt: assert property (p_cnt) else $error("wait count wrong");
  property p_dat; rd_valid_reg |-> rd_data_reg == dat_reg; endproperty
  a_dat: assert property (p_dat) else $error("read data wrong");
  property p_cmd; cmd_valid && (cmd == 2'h1 || cmd == 2'h2) && !module_busy_reg[cmd_module]
    |=> module_busy_reg[$past(cmd_module)]; endproperty
  a_cmd: assert property (p_cmd) else $error("busy not raised");
  property p_ref; cmd_valid && (cmd == 2'h0 || cmd == 2'h3 || module_busy_reg[cmd_module])
    |=> cmd_refused_reg; endproperty
  a_ref: assert property (p_ref) else $error("command not refused");
  property p_done; $fell(module_busy_reg[1]) |-> module_done_reg[1]; endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_dur; $fell(module_busy_reg[0]) |-> c_reg >= t - 32'd20 && c_reg <= t + 32'd20;
  endproperty
  a_dur: assert property (p_dur) else $error("duration wrong");
  c_seq: cover property (take && seq);
  c_par: cover property (module_busy_reg == 2'h3);
  c_ref: cover property (cmd_refused_reg);
endmodule
bind faec_top faec_chk #(.ERASE_TICKS(ERASE_TICKS), .PROG_TICKS(PROG_TICKS)) u_chk (
  .clk(clk), .rst_b(rst_b), .flash_wait_state_count(flash_wait_state_count),
  .rd_req(rd_req), .rd_addr(rd_addr), .rd_module(rd_module), .array_rdata(array_rdata),
  .rd_valid_reg(rd_valid_reg), .rd_data_reg(rd_data_reg), .rd_busy_reg(rd_busy_reg),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_module(cmd_module),
  .cmd_refused_reg(cmd_refused_reg), .module_busy_reg(module_busy_reg),
  .module_done_reg(module_done_reg), .protect_active_reg(protect_active_reg));

//--- verification/faec_top_tb.sv
// self-checking bench for the flash access and erase controller
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH %0t value differs", $time); end end
module faec_top_tb;
  reg clk = 1'b0, rst_b = 1'b0, rd_req = 1'b0, cmd_valid = 1'b0;
  reg [2:0] ws = 3'h0;
  reg [15:0] addr = 16'h0;
  reg [0:0] mod = 1'h0, cm_m = 1'h0;
  reg [1:0] cmd = 2'h0;
  wire [15:0] ard, rdat;
  wire rv, rb, rf, prot;
  wire [1:0] mb, md;
  int err_count = 0, tests_run = 0, i, n, fq = 0, r;
  reg [15:0] rq[$];
  reg [0:0] dq[$];
  faec_top #(.ERASE_TICKS(5), .PROG_TICKS(3)) uut (.clk(clk), .rst_b(rst_b),
    .flash_wait_state_count(ws), .rd_req(rd_req), .rd_addr(addr), .rd_module(mod),
    .array_rdata(ard), .rd_valid_reg(rv), .rd_data_reg(rdat), .rd_busy_reg(rb),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_module(cm_m), .cmd_refused_reg(rf),
    .module_busy_reg(mb), .module_done_reg(md), .protect_active_reg(prot));
  faec_mem_model u_mem (.clk(clk), .rd_req(rd_req), .rd_addr(addr), .rd_module(mod),
    .array_rdata(ard));
  initial forever #5 clk = ~clk;
  task finish_test;
    begin
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task rd(input [15:0] a, input [0:0] m);
    begin
      rd_req = 1'b1; addr = a; mod = m;
      rq.push_back({m, a[14:0]} ^ 16'h3C3C);
      @(negedge clk);
      for (n = 0; rb !== 1'b0 && n < 20; n++) @(negedge clk);
      if (n == 20) begin err_count++; finish_test; end
    end
  endtask
  task cm(input [1:0] c, input [0:0] m, input bit bad);
    begin
      cmd_valid = 1'b1; cmd = c; cm_m = m;
      if (bad) fq++; else dq.push_back(m);
      @(negedge clk);
      cmd_valid = 1'b0;
      @(negedge clk);
    end
  endtask
  task idle;
    begin
      for (n = 0; mb !== 2'h0 && n < 400; n++) @(negedge clk);
      if (n == 400) begin err_count++; finish_test; end
    end
  endtask
  // results are judged a step after the edge so registered outputs have settled
  always @(posedge clk) begin
    #1;
    if (rv === 1'b1) `CHK(rdat, rq.pop_front())
    if (rf === 1'b1) begin `CHK(fq > 0, 1'b1) fq--; end
    if (md[0] === 1'b1) `CHK(dq.pop_front(), 1'h0)
    if (md[1] === 1'b1) `CHK(dq.pop_front(), 1'h1)
  end
  initial begin
    r = $urandom(35683);
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    `CHK(rdat, 16'hFFFF)
    `CHK(prot, 1'b0)
    for (i = 0; i < 5; i++) begin
      ws = 3'h4 + {1'b0, i[1:0]};
      r = $urandom;
      rd(r[15:0] & 16'hFFF0, r[16]);
      rd((r[15:0] & 16'hFFF0) + 16'h1, r[16]);
    end
    rd_req = 1'b0;
    ws = 3'h4;
    cm(2'h0, 1'h0, 1);
    cm(2'h3, 1'h1, 1);
    cm(2'h2, 1'h0, 0);
    cm(2'h1, 1'h1, 0);
    cm(2'h1, 1'h1, 1);
    `CHK(mb, 2'h3)
    idle;
    cm(2'h1, 1'h1, 0);
    `CHK(mb, 2'h2)
    for (i = 0; i < 6; i++) rd(16'h0100 + i[15:0], 1'h0);
    rd_req = 1'b0;
    idle;
    repeat (3) @(negedge clk);
    `CHK(rq.size() + dq.size() + fq, 0)
    finish_test;
  end
endmodule
